// >>> design/rmv_map.svh
`ifndef RMV_MAP_SVH
`define RMV_MAP_SVH
`define RMV_ADDR_CORE 8'h31
`define RMV_ADDR_DSW 8'h32
`define RMV_ADDR_PCH 8'h33
`define RMV_RST_CORE 8'h4a
`define RMV_RST_DSW 8'h2a
`define RMV_RST_PCH 8'h0a
`define RMV_PCH_RO_MASK 8'h0c
`define RMV_LP_HI 7
`define RMV_LP_LO 6
`define RMV_VS_HI 5
`define RMV_VS_LO 4
`define RMV_EX_HI 3
`define RMV_EX_LO 2
`define RMV_MD_HI 1
`define RMV_MD_LO 0
`define RMV_CODE_OFF 2'h0
`define RMV_CODE_FPWM 2'h3
`endif

// >>> design/rmv_pkg.sv
package rmv_pkg;
  typedef enum logic [1:0] {
    RMV_MODE_OFF,
    RMV_MODE_AUTO,
    RMV_MODE_FPWM
  } rmv_mode_t;
  typedef struct packed {
    logic [1:0] low_power_select;
    logic [1:0] voltage_select;
    logic [1:0] exit_standby_mode;
    logic [1:0] mode;
  } rmv_buck_t;
  typedef struct packed {
    logic [1:0] level;
    rmv_mode_t state;
    logic fast_change;
  } rmv_rail_t;
endpackage

// >>> design/rmv_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rmv_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d_n,
  output logic q_n
);
  logic s1_reg;
  logic s2_reg;
  logic s1_next;
  logic s2_next;
  // Inactive (high) at reset so no false wake edge appears
  always_comb begin
    s1_next = d_n;
    s2_next = s1_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  assign q_n = s2_reg;
endmodule
`default_nettype wire

// >>> design/rmv_rail.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmv_map.svh"
module rmv_rail (
  input wire logic clk,
  input wire logic rst,
  input wire logic asleep,
  input wire logic wake,
  input wire rmv_pkg::rmv_buck_t cfg,
  output rmv_pkg::rmv_rail_t rail
);
  rmv_pkg::rmv_rail_t rail_reg;
  rmv_pkg::rmv_rail_t rail_next;
  logic fast_reg;
  logic fast_next;
  function automatic rmv_pkg::rmv_mode_t decode_mode(input logic [1:0] c);
    if (c == `RMV_CODE_OFF)
      decode_mode = rmv_pkg::RMV_MODE_OFF;
    else if (c == `RMV_CODE_FPWM)
      decode_mode = rmv_pkg::RMV_MODE_FPWM;
    else
      decode_mode = rmv_pkg::RMV_MODE_AUTO;
  endfunction
  always_comb begin
    fast_next = fast_reg;
    if (wake)
      fast_next = (cfg.exit_standby_mode != `RMV_CODE_OFF);
    rail_next.fast_change = fast_next;
    rail_next.state = decode_mode(cfg.mode);
    rail_next.level = cfg.voltage_select;
    // Low-power code 0 keeps the normal selection
    if (asleep && cfg.low_power_select != `RMV_CODE_OFF)
      rail_next.level = cfg.low_power_select;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_reg <= 1'b1;
      rail_reg <= '0;
    end else begin
      fast_reg <= fast_next;
      rail_reg <= rail_next;
    end
  end
  assign rail = rail_reg;
endmodule
`default_nettype wire

// >>> design/rmv_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmv_map.svh"
module rmv_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_request_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output rmv_pkg::rmv_rail_t primary_core_rail,
  output rmv_pkg::rmv_rail_t deep_sleep_3v3_rail,
  output logic pch_switch_enable
);
  // ----------------------------------------------------------------
  // Sleep input
  // ----------------------------------------------------------------
  logic sleep_n_sync;
  logic sleep_prev_reg;
  logic sleep_prev_next;
  logic wake;
  logic asleep;
  rmv_sync u_sync (
    .clk(clk),
    .rst(rst),
    .d_n(sleep_request_n),
    .q_n(sleep_n_sync)
  );
  always_comb begin
    sleep_prev_next = sleep_n_sync;
  end
  always_ff @(posedge clk) begin
    if (rst)
      sleep_prev_reg <= 1'b1;
    else
      sleep_prev_reg <= sleep_prev_next;
  end
  assign asleep = ~sleep_n_sync;
  assign wake = sleep_n_sync & ~sleep_prev_reg;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  rmv_pkg::rmv_buck_t core_reg;
  rmv_pkg::rmv_buck_t core_next;
  rmv_pkg::rmv_buck_t dsw_reg;
  rmv_pkg::rmv_buck_t dsw_next;
  logic [7:0] pch_reg;
  logic [7:0] pch_next;
  always_comb begin
    core_next = core_reg;
    dsw_next = dsw_reg;
    pch_next = pch_reg;
    // Exit-standby copy first; a same-cycle bus write then wins
    if (wake && core_reg.exit_standby_mode != `RMV_CODE_OFF)
      core_next.mode = core_reg.exit_standby_mode;
    if (wake && dsw_reg.exit_standby_mode != `RMV_CODE_OFF)
      dsw_next.mode = dsw_reg.exit_standby_mode;
    if (reg_wr) begin
      case (reg_addr)
        `RMV_ADDR_CORE: core_next = reg_wdata;
        `RMV_ADDR_DSW: dsw_next = reg_wdata;
        `RMV_ADDR_PCH: begin
          // Keep the read-only bits, whatever is written
          pch_next = (reg_wdata & ~`RMV_PCH_RO_MASK) |
                     (`RMV_RST_PCH & `RMV_PCH_RO_MASK);
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reg <= `RMV_RST_CORE;
      dsw_reg <= `RMV_RST_DSW;
      pch_reg <= `RMV_RST_PCH;
    end else begin
      core_reg <= core_next;
      dsw_reg <= dsw_next;
      pch_reg <= pch_next;
    end
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    reg_hit = 1'b1;
    case (reg_addr)
      `RMV_ADDR_CORE: reg_rdata = core_reg;
      `RMV_ADDR_DSW: reg_rdata = dsw_reg;
      `RMV_ADDR_PCH: reg_rdata = pch_reg;
      default: begin
        reg_rdata = 8'h00;
        reg_hit = 1'b0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Rail control
  // ----------------------------------------------------------------
  rmv_rail u_core (
    .clk(clk),
    .rst(rst),
    .asleep(asleep),
    .wake(wake),
    .cfg(core_reg),
    .rail(primary_core_rail)
  );
  rmv_rail u_dsw (
    .clk(clk),
    .rst(rst),
    .asleep(asleep),
    .wake(wake),
    .cfg(dsw_reg),
    .rail(deep_sleep_3v3_rail)
  );
  logic pch_en_reg;
  logic pch_en_next;
  always_comb begin
    pch_en_next = (pch_reg[`RMV_MD_HI:`RMV_MD_LO] != `RMV_CODE_OFF);
  end
  always_ff @(posedge clk) begin
    if (rst)
      pch_en_reg <= 1'b0;
    else
      pch_en_reg <= pch_en_next;
  end
  assign pch_switch_enable = pch_en_reg;
endmodule
`default_nettype wire

// >>> testbench/rmv_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rmv_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_request_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire rmv_pkg::rmv_rail_t primary_core_rail,
  input wire rmv_pkg::rmv_rail_t deep_sleep_3v3_rail,
  input wire logic pch_switch_enable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [1:0] lvl;
  logic [1:0] md;
  logic c1;
  logic c2;
  // Rails lag the pin through the synchroniser: judge settled windows only
  assign lvl = (sleep_request_n || reg_rdata[7:6] == 2'h0) ?
    reg_rdata[5:4] : reg_rdata[7:6];
  assign md = reg_rdata[1:0];
  assign c1 = !reg_wr && reg_addr == 8'h31;
  assign c2 = !reg_wr && reg_addr == 8'h32;
  a_hit_decode: assert property (
    reg_hit == (reg_addr >= 8'h31 && reg_addr <= 8'h33)) else $error("hit");
  a_unmapped_zero: assert property (!reg_hit |-> reg_rdata == 8'h00)
    else $error("unmapped");
  a_pch_fixed: assert property (
    reg_addr == 8'h33 |-> reg_rdata[3:2] == 2'h2) else $error("fixed");
  a_write_echo: assert property (
    reg_wr && reg_addr == 8'h31 ##1 reg_addr == 8'h31
    |-> reg_rdata == $past(reg_wdata)) else $error("echo");
  a_core_level: assert property (
    (c1 && $stable(sleep_request_n))[*6]
    |-> primary_core_rail.level == lvl) else $error("core level");
  a_dsw_level: assert property (
    (c2 && $stable(sleep_request_n))[*6]
    |-> deep_sleep_3v3_rail.level == lvl) else $error("dsw level");
  a_core_state: assert property (
    (c1 && $stable(sleep_request_n))[*6]
    |-> primary_core_rail.state == (md == 2'h3 ? 2'h2 : {1'b0, |md}))
    else $error("state");
  a_pch_enable: assert property (
    (!reg_wr && reg_addr == 8'h33)[*2]
    |-> pch_switch_enable == (md != 2'h0)) else $error("switch");
endmodule
bind rmv_top rmv_checker u_chk (.*);
`default_nettype wire

// >>> testbench/rmv_host.sv
`timescale 1ns/1ps
`default_nettype none
module rmv_host (
  input wire logic clk,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic sleep_request_n
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h31;
    reg_wdata = 8'h00;
    sleep_request_n = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Stale data inverted so a late capture cannot look right
    reg_wdata = ~d;
  endtask
  task automatic go(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
  endtask
  task automatic pin(input logic v);
    @(negedge clk);
    sleep_request_n = v;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_rmv_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rmv_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, sleep_request_n, reg_hit, pch_switch_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a, d;
  rmv_pkg::rmv_rail_t primary_core_rail, deep_sleep_3v3_rail;
  logic v_fast;
  int fail_count = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  rmv_host host (.*);
  rmv_top dut (.*);
  function automatic logic [3:0] want(input logic [7:0] r, input logic s);
    want[3:2] = (s || r[7:6] == 2'h0) ? r[5:4] : r[7:6];
    want[1:0] = r[1:0] == 2'h3 ? 2'h2 : {1'b0, r[1:0] != 2'h0};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    host.go(ad);
    #10;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic rail(input logic s);
    logic [4:0] v;
    repeat (6) @(negedge clk);
    v = a[0] ? primary_core_rail : deep_sleep_3v3_rail;
    chk("rail", {4'h0, want(d, s)}, {4'h0, v[4:1]});
  endtask
  task automatic give_verdict;
    $display("compared %0d wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(38));
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rd(8'h31, 8'h4a);
    rd(8'h32, 8'h2a);
    rd(8'h33, 8'h0a);
    rd(8'h34, 8'h00);
    host.wr(8'h33, 8'hff);
    rd(8'h33, 8'hfb);
    for (int i = 0; i < 8; i++) begin
      a = i[2] ? 8'h32 : 8'h31;
      d = 8'($urandom);
      d[3:2] = i[1:0];
      host.wr(a, d);
      rd(a, d);
      rail(1'b1);
      host.pin(1'b0);
      rail(1'b0);
      host.pin(1'b1);
      if (d[3:2] != 2'h0) d[1:0] = d[3:2];
      rail(1'b1);
      v_fast = a[0] ? primary_core_rail.fast_change :
        deep_sleep_3v3_rail.fast_change;
      chk("fast_change", {7'h0, d[3:2] != 2'h0}, {7'h0, v_fast});
      rd(a, d);
    end
    host.wr(8'h33, 8'h00);
    rd(8'h33, 8'h08);
    @(negedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
